// *** rtl/pcu_map.svh ***
// register map, field positions and reset values of the pin change unit
// How it works
// - group two raises request on lines 23..16
// - group one raises request on lines 14..8
// - group zero raises request on lines 7..0
// - each group served through its own vector
// - pin change sets flags at bits 2..0
// - vector taken only when flag, enable, global
// - entering a group routine clears its flag
// - write one clears flag, zero keeps
// - pin counts only with mask and enable
// - enable and flag bits 7..3 read zero
// - group one mask bit 7 reads zero
// - changes caught without program involvement, wake capable
// - pins trigger even when driven as outputs
`ifndef PCU_MAP_SVH
`define PCU_MAP_SVH

`define PCU_OFS_GROUP_ENABLE 8'h68
`define PCU_OFS_GROUP_FLAGS  8'h69
`define PCU_OFS_MASK_LOW     8'h6B
`define PCU_OFS_MASK_MID     8'h6C
`define PCU_OFS_MASK_HIGH    8'h6D

`define PCU_RST_BYTE         8'h00
`define PCU_RST_GROUP        3'h0
`define PCU_GROUP_BITS       3'h7
`define PCU_MID_MASK_BITS    8'h7F

`define PCU_GRP_ZERO         0
`define PCU_GRP_ONE          1
`define PCU_GRP_TWO          2

`define PCU_LINES            24
`define PCU_GROUPS           3

`endif

// *** rtl/pcu_pkg.sv ***
// types shared by the pin change unit
package pcu_pkg;

  typedef logic [7:0] pcu_byte_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcu_bus_req_t;

  typedef struct packed {
    logic vec_two;
    logic vec_one;
    logic vec_zero;
  } pcu_vec_t;

endpackage

// *** rtl/pcu_sync.sv ***
// three stage pin synchroniser with change detection
`timescale 1ns/1ns
module pcu_sync #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // raw pins and one-cycle change pulses
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] changed
);

  logic [W-1:0] s1_q, s2_q, s3_q, level_q, level_d;
  logic         primed_q, primed_d;
  logic [W-1:0] agree;

  if (W < 1)
  begin : g_bad_width
    $error("pcu_sync: width must be at least one");
  end

  // a change counts once stages two and three agree
  always_comb
  begin
    agree    = ~(s2_q ^ s3_q);
    primed_d = 1'b1;
    level_d  = (level_q & ~agree) | (s3_q & agree);
    changed  = primed_q ? (agree & (s3_q ^ level_q)) : '0;
    if (!primed_q)
    begin
      level_d = s3_q;
    end
  end

  // pins are sampled on every rising edge, whatever drives them
  always_ff @(posedge clk)
  begin
    // stages run through reset so the first baseline is the settled pin level
    s1_q <= raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (reset)
    begin
      level_q  <= '0;
      primed_q <= 1'b0;
    end
    else
    begin
      level_q  <= level_d;
      primed_q <= primed_d;
    end
  end

endmodule

// *** rtl/pcu_unit.sv ***
// pin change interrupt unit: masks, group enables, flags and vectors
`timescale 1ns/1ns
`include "pcu_map.svh"
module pcu_unit #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // register port
  input  wire pcu_pkg::pcu_bus_req_t bus_req,
  output logic      [7:0]            bus_rdata,
  // watched pins, bit 15 unused
  input  wire logic [23:0]           watched_pin_line,
  // core side
  input  wire logic                  global_irq_enable,
  input  wire pcu_pkg::pcu_vec_t     vector_taken,
  output pcu_pkg::pcu_vec_t          vector_request,
  output logic                       irq,
  output logic                       wake
);
  import pcu_pkg::*;

  if (ADDR_W != 8)
  begin : g_bad_addr
    $error("pcu_unit: register port address must be 8 bits");
  end

  // ---------------- synchronised change detection ----------------
  logic [23:0] line_changed;

  pcu_sync #(
    .W (`PCU_LINES)
  ) u_sync (
    .clk     (clk),
    .reset   (reset),
    .raw     (watched_pin_line),
    .changed (line_changed)
  );

  // ---------------- registers ----------------
  pcu_byte_t   mask_low_q, mask_low_d;
  pcu_byte_t   mask_mid_q, mask_mid_d;
  pcu_byte_t   mask_high_q, mask_high_d;
  logic [2:0]  enable_q, enable_d;
  logic [2:0]  flags_q, flags_d;
  pcu_byte_t   rdata_q, rdata_d;
  pcu_vec_t    vec_q, vec_d;
  logic        irq_q, irq_d;
  logic        wake_q, wake_d;

  logic        wr_enable, wr_flags, wr_low, wr_mid, wr_high;
  logic [23:0] mask_all;
  logic [23:0] live;
  logic [2:0]  grp_evt;
  logic [2:0]  flag_clr;
  logic [2:0]  taken;
  logic [2:0]  pending;

  always_comb
  begin
    wr_enable = bus_req.wr && bus_req.addr == `PCU_OFS_GROUP_ENABLE;
    wr_flags  = bus_req.wr && bus_req.addr == `PCU_OFS_GROUP_FLAGS;
    wr_low    = bus_req.wr && bus_req.addr == `PCU_OFS_MASK_LOW;
    wr_mid    = bus_req.wr && bus_req.addr == `PCU_OFS_MASK_MID;
    wr_high   = bus_req.wr && bus_req.addr == `PCU_OFS_MASK_HIGH;

    // mid mask bit 7 is always zero, so line 15 never contributes
    mask_all  = {mask_high_q, mask_mid_q, mask_low_q};
    live      = line_changed & mask_all;

    // a group event needs an unmasked change and the group enable
    grp_evt[`PCU_GRP_TWO]  = |live[23:16] && enable_q[`PCU_GRP_TWO];
    grp_evt[`PCU_GRP_ONE]  = |live[14:8]  && enable_q[`PCU_GRP_ONE];
    grp_evt[`PCU_GRP_ZERO] = |live[7:0]   && enable_q[`PCU_GRP_ZERO];

    taken = {vector_taken.vec_two, vector_taken.vec_one, vector_taken.vec_zero};
  end

  // mask and enable registers
  always_comb
  begin
    mask_low_d  = mask_low_q;
    mask_mid_d  = mask_mid_q;
    mask_high_d = mask_high_q;
    enable_d    = enable_q;
    if (wr_low)
    begin
      mask_low_d = bus_req.wdata;
    end
    if (wr_mid)
    begin
      mask_mid_d = bus_req.wdata & `PCU_MID_MASK_BITS;
    end
    if (wr_high)
    begin
      mask_high_d = bus_req.wdata;
    end
    if (wr_enable)
    begin
      enable_d = bus_req.wdata[2:0] & `PCU_GROUP_BITS;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mask_low_q  <= `PCU_RST_BYTE;
      mask_mid_q  <= `PCU_RST_BYTE;
      mask_high_q <= `PCU_RST_BYTE;
      enable_q    <= `PCU_RST_GROUP;
    end
    else
    begin
      mask_low_q  <= mask_low_d;
      mask_mid_q  <= mask_mid_d;
      mask_high_q <= mask_high_d;
      enable_q    <= enable_d;
    end
  end

  // flags: a new event wins over a clear in the same cycle
  always_comb
  begin
    flag_clr = taken;
    if (wr_flags)
    begin
      flag_clr = flag_clr | bus_req.wdata[2:0];
    end
    flags_d = (flags_q & ~flag_clr) | grp_evt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags_q <= `PCU_RST_GROUP;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // vector requests, interrupt level and wake pulse
  always_comb
  begin
    pending        = flags_d & enable_d;
    vec_d.vec_two  = pending[`PCU_GRP_TWO]  && global_irq_enable;
    vec_d.vec_one  = pending[`PCU_GRP_ONE]  && global_irq_enable;
    vec_d.vec_zero = pending[`PCU_GRP_ZERO] && global_irq_enable;
    irq_d          = |pending;
    wake_d         = |grp_evt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      vec_q  <= '0;
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      vec_q  <= vec_d;
      irq_q  <= irq_d;
      wake_q <= wake_d;
    end
  end

  // read port, data in the cycle after the strobe
  always_comb
  begin
    rdata_d = `PCU_RST_BYTE;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `PCU_OFS_GROUP_ENABLE: rdata_d = {5'h00, enable_q};
        `PCU_OFS_GROUP_FLAGS:  rdata_d = {5'h00, flags_q};
        `PCU_OFS_MASK_LOW:     rdata_d = mask_low_q;
        `PCU_OFS_MASK_MID:     rdata_d = mask_mid_q;
        `PCU_OFS_MASK_HIGH:    rdata_d = mask_high_q;
        default:               rdata_d = `PCU_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_q <= `PCU_RST_BYTE;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata      = rdata_q;
  assign vector_request = vec_q;
  assign irq            = irq_q;
  assign wake           = wake_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_group_two_set:
    assert property (grp_evt[2] |=> flags_q[2])
    else $error("group two change did not set its flag");

  a_group_one_set:
    assert property (|(line_changed[14:8] & mask_mid_q[6:0]) && enable_q[1]
                     |=> flags_q[1])
    else $error("group one change did not set its flag");

  a_group_zero_set:
    assert property (|(line_changed[7:0] & mask_low_q) && enable_q[0]
                     |=> flags_q[0])
    else $error("group zero change did not set its flag");

  a_vector_own_group:
    assert property (vec_q.vec_one |-> flags_q[1] && enable_q[1])
    else $error("group one vector without its own pending flag");

  a_flag_rise_cause:
    assert property ($rose(flags_q[0]) |-> $past(grp_evt[0]))
    else $error("group zero flag rose without an event");

  a_vector_needs_gie:
    assert property (vec_q.vec_two |-> $past(global_irq_enable)
                     && flags_q[2] && enable_q[2])
    else $error("group two vector without flag, enable and global enable");

  a_taken_clears:
    assert property (vector_taken.vec_zero && !grp_evt[0] |=> !flags_q[0])
    else $error("taking group zero vector did not clear its flag");

  a_w1c_clears:
    assert property (wr_flags && bus_req.wdata[1] && !grp_evt[1]
                     |=> !flags_q[1])
    else $error("writing one did not clear group one flag");

  a_zero_write_keeps:
    assert property (wr_flags && !bus_req.wdata[2] && flags_q[2]
                     && !vector_taken.vec_two |=> flags_q[2])
    else $error("writing zero changed group two flag");

  a_masked_pin_silent:
    assert property (mask_all == 24'h000000 && !flags_q[1] && !wr_flags
                     |=> !flags_q[1])
    else $error("flag set with every pin masked");

  a_reserved_read_zero:
    assert property (bus_req.rd && (bus_req.addr == `PCU_OFS_GROUP_ENABLE
                     || bus_req.addr == `PCU_OFS_GROUP_FLAGS)
                     |=> bus_rdata[7:3] == 5'h00)
    else $error("reserved enable or flag bits read nonzero");

  a_mid_bit7_zero:
    assert property (bus_req.rd && bus_req.addr == `PCU_OFS_MASK_MID
                     |=> !bus_rdata[7])
    else $error("group one mask bit 7 read as one");

  a_wake_follows:
    assert property (grp_evt != 3'h0 |=> wake ##1 !wake || $past(|grp_evt))
    else $error("wake pulse missing after group event");

  a_irq_level:
    assert property (irq == |(flags_q & enable_q))
    else $error("interrupt level disagrees with flags and enables");

  a_group_two_taken:
    assert property (vector_taken.vec_two && !grp_evt[2] |=> !flags_q[2])
    else $error("taking group two vector did not clear its flag");

  a_vector_zero_own:
    assert property (vec_q.vec_zero |-> flags_q[0] && enable_q[0])
    else $error("group zero vector without its own pending flag");

  a_vector_off_no_gie:
    assert property (!$past(global_irq_enable) |-> vec_q == 3'h0)
    else $error("vector request while global enable was low");

  a_wake_has_cause:
    assert property ($rose(wake) |-> $past(|grp_evt))
    else $error("wake pulse without a group event");

  c_vector_taken:
    cover property (vec_q.vec_two ##[1:20] vector_taken.vec_two);
  c_set_and_clear:
    cover property (grp_evt[1] && wr_flags && bus_req.wdata[1]);
  c_all_pending:
    cover property (flags_q == 3'h7);
  c_mask_readback:
    cover property (bus_req.rd && bus_req.addr == `PCU_OFS_MASK_MID ##1 bus_rdata != 8'h00);
  c_wake_pulse:
    cover property (wake);

endmodule

// *** testbench/pcu_pin_model.sv ***
// outside world that drives the watched pin lines
`timescale 1ns/1ns
module pcu_pin_model (
  // clock
  input  wire logic        clk,
  // pin levels seen by the unit
  output logic      [23:0] pins
);
  initial pins = 24'h000000;

  // a pin driven as output looks the same as one driven from outside
  task automatic flip(input int idx);
    @(posedge clk);
    pins[idx] <= ~pins[idx];
  endtask
endmodule

// *** testbench/pin_change_interrupt_unit_tb.sv ***
// self-checking bench of the pin change unit
`timescale 1ns/1ns
`include "pcu_map.svh"
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); \
    end \
  end
module pin_change_interrupt_unit_tb;
  import pcu_pkg::*;
  logic         clk;
  logic         reset;
  logic         glob;
  logic         rd_seen;
  pcu_bus_req_t req;
  pcu_vec_t     taken;
  pcu_vec_t     vreq;
  logic [7:0]   rdata;
  logic [23:0]  pins;
  logic         irq;
  logic         wake;
  int           n_wake;
  logic [11:0]  exp_q[$];
  logic [11:0]  exp_w;
  logic [2:0]   flg;
  logic [2:0]   en;
  logic [7:0]   m;
  logic [7:0]   mv;
  logic [7:0]   mofs[3];
  int           b;
  int           p;
  int           n_errors;
  int           checks_done;
  int           cyc;

  pcu_pin_model u_pins (.clk(clk), .pins(pins));
  pcu_unit u_dut (
    .clk              (clk),
    .reset            (reset),
    .bus_req          (req),
    .bus_rdata        (rdata),
    .watched_pin_line (pins),
    .global_irq_enable(glob),
    .vector_taken     (taken),
    .vector_request   (vreq),
    .irq              (irq),
    .wake             (wake)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, far above the roughly two hundred cycles the tests take
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // the read note holds irq, requests and read data expected next cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back({|(flg & en), flg & en & {3{glob}}, e});
    @(posedge clk);
    req.rd <= 1'b0;
  endtask

  always @(posedge clk) rd_seen <= req.rd;

  always @(negedge clk)
    if (rd_seen === 1'b1)
    begin
      exp_w = exp_q.pop_front();
      `CHK({irq, vreq, rdata}, exp_w)
    end

  // wake pulses are counted and held against the events each scenario causes
  always @(negedge clk)
    if (wake === 1'b1)
      n_wake++;

  initial
  begin
    reset = 1'b1;
    glob = 1'b0;
    taken = '0;
    req = '0;
    n_wake = 0;
    flg = 3'h0;
    en = 3'h0;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    mofs = '{`PCU_OFS_MASK_LOW, `PCU_OFS_MASK_MID, `PCU_OFS_MASK_HIGH};
    void'($urandom(70782));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`PCU_OFS_GROUP_ENABLE, 8'h00);
    rd(`PCU_OFS_GROUP_FLAGS, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      rd(mofs[i], 8'h00);
      mv = 8'($urandom);
      wr(mofs[i], mv);
      rd(mofs[i], (i == 1) ? (mv & 8'h7F) : mv);
    end
    wr(8'h6A, 8'hFF);
    rd(8'h6A, 8'h00);
    wr(`PCU_OFS_GROUP_FLAGS, 8'hFF);
    rd(`PCU_OFS_GROUP_FLAGS, 8'h00);
    for (int g = 0; g < 3; g++)
    begin
      b = (g == 1) ? ($urandom % 7) : ($urandom % 8);
      p = 8 * g + b;
      m = 8'h01 << b;
      glob <= (g != 1);
      // masked-out pin, then enabled pin in a disabled group
      wr(`PCU_OFS_GROUP_ENABLE, 8'h07);
      en = 3'h7;
      wr(mofs[g], ~m);
      u_pins.flip(p);
      repeat (6) @(posedge clk);
      rd(`PCU_OFS_GROUP_FLAGS, 8'h00);
      `CHK(n_wake, g)
      en = 3'h7 & ~(3'h1 << g);
      wr(`PCU_OFS_GROUP_ENABLE, {5'h00, en});
      mv = 8'($urandom) | m;
      wr(mofs[g], mv);
      u_pins.flip(p);
      repeat (6) @(posedge clk);
      rd(`PCU_OFS_GROUP_FLAGS, 8'h00);
      `CHK(n_wake, g)
      en = 3'h7;
      wr(`PCU_OFS_GROUP_ENABLE, 8'h07);
      u_pins.flip(p);
      repeat (6) @(posedge clk);
      flg = 3'h1 << g;
      rd(`PCU_OFS_GROUP_FLAGS, {5'h00, flg});
      `CHK(n_wake, g + 1)
      wr(`PCU_OFS_GROUP_FLAGS, 8'hF8);
      @(posedge clk);
      taken <= pcu_vec_t'(3'(3'h1 << ((g + 1) % 3)));
      @(posedge clk);
      taken <= '0;
      rd(`PCU_OFS_GROUP_FLAGS, {5'h00, flg});
      if (g == 0)
        wr(`PCU_OFS_GROUP_FLAGS, {5'h00, flg});
      else
      begin
        @(posedge clk);
        taken <= pcu_vec_t'(flg);
        @(posedge clk);
        taken <= '0;
      end
      flg = 3'h0;
      rd(`PCU_OFS_GROUP_FLAGS, 8'h00);
    end
    wr(`PCU_OFS_MASK_MID, 8'hFF);
    u_pins.flip(15);
    repeat (6) @(posedge clk);
    rd(`PCU_OFS_GROUP_FLAGS, 8'h00);
    `CHK(n_wake, 3)
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
